// ### hdl/wwds_pkg.sv
// Purpose: shared constants and types of the windowed watchdog supervisor
// Assumes: aclk at 40 MHz, 32-bit AXI4-Lite register bus
// Notes: times are kept as printed, cycle counts are derived from them
package wwds_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned KICK_TIMEOUT_NS = 24_600_000;
  localparam int unsigned RESET_PERIOD_NS = 14_500_000;
  // longest time rounds down, least time rounds up
  localparam int unsigned KICK_TIMEOUT_CYC = KICK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned RESET_PERIOD_CYC = (RESET_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DP_DIV_SHIFT = 5;

  localparam logic [7:0] OFS_TIMEOUT = 8'h00;
  localparam logic [7:0] OFS_RESET = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;

  localparam int unsigned INT_W = 3;
  localparam int unsigned INT_TIMEOUT = 0;
  localparam int unsigned INT_EARLY = 1;
  localparam int unsigned INT_SUPPLY = 2;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  localparam int unsigned ST_RUNNING = 0;
  localparam int unsigned ST_HOLDING = 1;
  localparam int unsigned ST_WINDOW = 2;
  localparam int unsigned ST_ENABLED = 3;
  localparam int unsigned ST_SUPPLY = 4;
  localparam int unsigned ST_FAULT_PIN = 5;
  localparam int unsigned ST_RESET_PIN = 6;

  // synchroniser lanes
  localparam int unsigned IN_W = 6;
  localparam int unsigned IN_KICK = 0;
  localparam int unsigned IN_MODE = 1;
  localparam int unsigned IN_EN = 2;
  localparam int unsigned IN_SUPPLY = 3;
  localparam int unsigned IN_FAULT = 4;
  localparam int unsigned IN_RESET = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KICK_RISE, KICK_FALL, KICK_BOTH} wwds_edge_t;
  typedef enum logic [1:0] {PH_OFF, PH_RUN, PH_HOLD} wwds_phase_t;
endpackage : wwds_pkg

// ### hdl/wwds_insync.sv
// Purpose: two-flop synchroniser with edge flags for pin inputs
// Assumes: inputs asynchronous to aclk
// Notes: edges are taken between second and third stage only
`timescale 1ns/1ps
`default_nettype none
module wwds_insync #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
  } wwds_sync_t;
  wwds_sync_t s_q, s_d;

  always_comb begin
    s_d.meta = pin;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync;
  assign rise = s_q.sync & ~s_q.last;
  assign fall = ~s_q.sync & s_q.last;
endmodule : wwds_insync
`default_nettype wire

// ### hdl/wwds_hold.sv
// Purpose: one-shot hold timer
// Assumes: period of at least one cycle
// Notes: a new start reloads the count
`timescale 1ns/1ps
`default_nettype none
module wwds_hold #(
  parameter int unsigned CW = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [CW-1:0] period,
  output logic busy
);
  typedef struct packed {
    logic run;
    logic [CW-1:0] cnt;
  } wwds_hold_t;
  wwds_hold_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.run = 1'b1;
      s_d.cnt = '0;
    end else if (s_q.run) begin
      if (s_q.cnt >= period - 1'b1) begin
        s_d.run = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.run;
endmodule : wwds_hold
`default_nettype wire

// ### hdl/wwds_top.sv
// Purpose: windowed watchdog supervisor with AXI4-Lite registers
// Assumes: pins asynchronous, supply_low from an analog detector
// Notes: periods are cycle counts held in writable registers
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module wwds_top #(
  parameter logic HAS_MODE_PIN = 1'b1,
  parameter logic EN_ACTIVE_HIGH = 1'b1,
  parameter wwds_pkg::wwds_edge_t KICK_EDGE = wwds_pkg::KICK_RISE,
  parameter logic [31:0] KICK_TIMEOUT_CYC = 32'(wwds_pkg::KICK_TIMEOUT_CYC),
  parameter logic [31:0] RESET_PERIOD_CYC = 32'(wwds_pkg::RESET_PERIOD_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic kick_input,
  input wire logic mode_select,
  input wire logic watchdog_enable,
  input wire logic supply_low,
  input wire logic fault_output_i,
  output logic fault_output_o,
  output logic fault_output_oe,
  input wire logic reset_output_i,
  output logic reset_output_o,
  output logic reset_output_oe,
  output logic irq
);
  import wwds_pkg::*;

  typedef struct packed {
    wwds_phase_t ph;
    logic win;
    logic [31:0] cnt;
    logic [31:0] timeout;
    logic [31:0] rst_per;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic fo_oe;
    logic ro_oe;
    logic drv_lvl;
    logic aw_have;
    logic [7:0] awaddr;
    logic awrdy;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic ardy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wwds_core_t;
  wwds_core_t s_q, s_d;

  logic [IN_W-1:0] pin_lvl, pin_rise, pin_fall;
  logic hold_busy;
  logic wd_en, kick_ev, supply_bad, ok, early, expired;
  logic [31:0] dp_cyc, closed_cyc, status;
  logic [INT_W-1:0] ev, w1c;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_TIMEOUT || a == OFS_RESET || a == OFS_STATUS ||
           a == OFS_INT_STAT || a == OFS_INT_MASK;
  endfunction : is_mapped

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  wwds_insync #(.W(IN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({reset_output_i, fault_output_i, supply_low, watchdog_enable, mode_select, kick_input}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // reset period continues after the supply recovers
  wwds_hold #(.CW(32)) u_supply_hold (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(pin_fall[IN_SUPPLY]),
    .period(s_q.rst_per),
    .busy(hold_busy)
  );

  always_comb begin
    wd_en = EN_ACTIVE_HIGH ? pin_lvl[IN_EN] : ~pin_lvl[IN_EN];
    unique case (KICK_EDGE)
      KICK_RISE: kick_ev = pin_rise[IN_KICK];
      KICK_FALL: kick_ev = pin_fall[IN_KICK];
      default: kick_ev = pin_rise[IN_KICK] | pin_fall[IN_KICK];
    endcase
    // fall cycle bridges the gap before the hold timer runs
    supply_bad = pin_lvl[IN_SUPPLY] | pin_fall[IN_SUPPLY] | hold_busy;
    ok = wd_en & ~supply_bad;
    dp_cyc = s_q.timeout >> DP_DIV_SHIFT;
    closed_cyc = dp_cyc + dp_cyc;
    early = s_q.win & (s_q.cnt < closed_cyc);
    expired = s_q.cnt >= s_q.timeout - 32'h0000_0001;
    status = '0;
    status[ST_RUNNING] = s_q.ph == PH_RUN;
    status[ST_HOLDING] = s_q.ph == PH_HOLD;
    status[ST_WINDOW] = s_q.win;
    status[ST_ENABLED] = wd_en;
    status[ST_SUPPLY] = supply_bad;
    status[ST_FAULT_PIN] = pin_lvl[IN_FAULT];
    status[ST_RESET_PIN] = pin_lvl[IN_RESET];
  end

  always_comb begin
    s_d = s_q;
    ev = '0;
    w1c = '0;
    // watchdog sequencer
    unique case (s_q.ph)
      PH_OFF: begin
        s_d.cnt = '0;
        if (ok) begin
          s_d.ph = PH_RUN;
          s_d.win = HAS_MODE_PIN ? ~pin_lvl[IN_MODE] : 1'b1;
        end
      end
      PH_RUN: begin
        if (!ok) begin
          s_d.ph = PH_OFF;
        end else if (kick_ev && early) begin
          s_d.ph = PH_HOLD;
          s_d.cnt = '0;
          ev[INT_EARLY] = 1'b1;
        end else if (kick_ev) begin
          s_d.cnt = '0;
        end else if (expired) begin
          s_d.ph = PH_HOLD;
          s_d.cnt = '0;
          ev[INT_TIMEOUT] = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
      end
      PH_HOLD: begin
        if (s_q.cnt >= s_q.rst_per - 32'h0000_0001) begin
          s_d.ph = ok ? PH_RUN : PH_OFF;
          s_d.cnt = '0;
        end else begin
          s_d.cnt = s_q.cnt + 32'h0000_0001;
        end
      end
      default: begin
        s_d.ph = PH_OFF;
      end
    endcase
    ev[INT_SUPPLY] = pin_rise[IN_SUPPLY];

    // write channel
    if (s_axi_awvalid && s_q.awrdy) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wrdy) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = is_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.awaddr)
        OFS_TIMEOUT: s_d.timeout = merge(s_q.timeout, s_q.wdata, s_q.wstrb);
        OFS_RESET: s_d.rst_per = merge(s_q.rst_per, s_q.wdata, s_q.wstrb);
        OFS_INT_STAT: w1c = s_q.wstrb[0] ? s_q.wdata[INT_W-1:0] : '0;
        OFS_INT_MASK: begin
          if (s_q.wstrb[0]) begin
            s_d.int_mask = s_q.wdata[INT_W-1:0];
          end
        end
        default: ;
      endcase
    end
    s_d.awrdy = ~s_d.aw_have & ~s_d.bvalid;
    s_d.wrdy = ~s_d.w_have & ~s_d.bvalid;

    // read channel
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.ardy) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_TIMEOUT: s_d.rdata = s_q.timeout;
        OFS_RESET: s_d.rdata = s_q.rst_per;
        OFS_STATUS: s_d.rdata = status;
        OFS_INT_STAT: s_d.rdata = {{(32-INT_W){1'b0}}, s_q.int_stat};
        OFS_INT_MASK: s_d.rdata = {{(32-INT_W){1'b0}}, s_q.int_mask};
        default: s_d.rdata = '0;
      endcase
    end
    s_d.ardy = ~s_d.rvalid;

    // set wins over a same-cycle clear
    s_d.int_stat = (s_q.int_stat & ~w1c) | ev;
    s_d.irq = |(s_d.int_stat & s_d.int_mask);
    // outputs only ever pull low
    s_d.drv_lvl = 1'b0;
    s_d.fo_oe = (s_d.ph == PH_HOLD) | supply_bad;
    s_d.ro_oe = ~HAS_MODE_PIN & supply_bad;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.ph <= PH_OFF;
      s_q.timeout <= KICK_TIMEOUT_CYC;
      s_q.rst_per <= RESET_PERIOD_CYC;
      s_q.int_mask <= INT_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awrdy;
  assign s_axi_wready = s_q.wrdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ardy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign fault_output_o = s_q.drv_lvl;
  assign fault_output_oe = s_q.fo_oe;
  assign reset_output_o = s_q.drv_lvl;
  assign reset_output_oe = s_q.ro_oe;
  assign irq = s_q.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_timeout_fault;
    (s_q.ph == PH_RUN && ok && !kick_ev && expired) |=> (s_q.ph == PH_HOLD && fault_output_oe);
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) else $error("missed kick did not fault");

  property p_early_kick;
    (s_q.ph == PH_RUN && ok && s_q.win && kick_ev && s_q.cnt < closed_cyc)
      |=> (s_q.ph == PH_HOLD && s_q.int_stat[INT_EARLY]);
  endproperty
  a_early_kick: assert property (p_early_kick) else $error("early kick not flagged");

  property p_window_edge;
    (s_q.ph == PH_RUN && ok && s_q.win && kick_ev && s_q.cnt == (s_q.timeout >> 5) * 2 - 1)
      |=> s_q.ph == PH_HOLD;
  endproperty
  a_window_edge: assert property (p_window_edge) else $error("closed window too short");

  property p_good_kick;
    (s_q.ph == PH_RUN && ok && kick_ev && !early) |=> (s_q.ph == PH_RUN && s_q.cnt == 0);
  endproperty
  a_good_kick: assert property (p_good_kick) else $error("good kick did not restart");

  property p_disable;
    (s_q.ph == PH_RUN && !wd_en) |=> (s_q.ph == PH_OFF ##1 s_q.cnt == 0);
  endproperty
  a_disable: assert property (p_disable) else $error("watchdog ran while disabled");

  property p_edge_kind;
    (s_q.ph == PH_RUN && ok && !expired && s_q.cnt > 0 &&
     ((KICK_EDGE == KICK_RISE && pin_fall[IN_KICK]) || (KICK_EDGE == KICK_FALL && pin_rise[IN_KICK])))
      |=> s_q.cnt == $past(s_q.cnt) + 1;
  endproperty
  a_edge_kind: assert property (p_edge_kind) else $error("wrong edge kind accepted");

  property p_fault_sources;
    (supply_bad || s_d.ph == PH_HOLD) |=> fault_output_oe;
  endproperty
  a_fault_sources: assert property (p_fault_sources) else $error("fault output not pulled low");

  property p_reset_supply_only;
    1 |=> reset_output_oe == (!HAS_MODE_PIN && $past(supply_bad));
  endproperty
  a_reset_supply_only: assert property (p_reset_supply_only) else $error("reset output wrong source");

  property p_window_fixed;
    (!HAS_MODE_PIN && s_q.ph == PH_RUN) |-> s_q.win;
  endproperty
  a_window_fixed: assert property (p_window_fixed) else $error("variant left window mode");

  property p_hold_len;
    (s_q.ph == PH_HOLD && s_q.cnt < s_q.rst_per - 1) |=> (s_q.ph == PH_HOLD && fault_output_oe);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("fault released early");

  property p_hold_end;
    (s_q.ph == PH_HOLD && s_q.cnt >= s_q.rst_per - 1 && ok) |=> (s_q.ph == PH_RUN && s_q.cnt == 0);
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("no restart after hold");

  property p_supply_release;
    pin_fall[IN_SUPPLY] |=> (fault_output_oe && hold_busy);
  endproperty
  a_supply_release: assert property (p_supply_release) else $error("fault dropped on supply recovery");

  property p_hold_drive;
    s_q.ph == PH_HOLD |-> fault_output_oe;
  endproperty
  a_hold_drive: assert property (p_hold_drive) else $error("fault not driven during hold");

  property p_supply_stop;
    (s_q.ph == PH_RUN && supply_bad) |=> s_q.ph == PH_OFF;
  endproperty
  a_supply_stop: assert property (p_supply_stop) else $error("watchdog ran with supply bad");
endmodule : wwds_top
`default_nettype wire

// ### tb/wwds_mcu.sv
// Purpose: model of the monitored controller that kicks the watchdog
// Assumes: each kick is a rise, a four-cycle high and a return low
// Notes: gap is the rise-to-rise spacing in aclk cycles, at least 5
`timescale 1ns/1ps
`default_nettype none
module wwds_mcu (
  input wire logic aclk,
  input wire logic run,
  input wire logic [15:0] gap,
  output logic kick = 1'b0
);
  logic [15:0] cnt_q = 16'h0000;

  always @(posedge aclk) begin
    if (!run) begin
      cnt_q <= 16'h0000;
      kick <= 1'b0;
    end else if (cnt_q >= gap - 16'h0001) begin
      // one rise per gap
      cnt_q <= 16'h0000;
      kick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      if (cnt_q == 16'h0003) begin
        kick <= 1'b0;
      end
    end
  end
endmodule : wwds_mcu
`default_nettype wire

// ### tb/tb_top.sv
// Purpose: self-checking bench of the windowed watchdog supervisor
// Assumes: short periods, time-out 256 and hold 20 cycles
// Notes: pins are pulled up, so a pin reads the inverse of its enable
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import wwds_pkg::*;
  localparam logic [31:0] TO = 32'h0000_0100;
  localparam logic [31:0] RS = 32'h0000_0014;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic kick;
  logic mode_select = 1'b0;
  logic watchdog_enable = 1'b0;
  logic supply_low = 1'b0;
  logic fault_output_o;
  logic fault_output_oe;
  logic reset_output_o;
  logic reset_output_oe;
  logic irq;
  logic run = 1'b0;
  logic [15:0] gap = 16'h0011;
  wire logic fault_pin = ~fault_output_oe;
  wire logic reset_pin = ~reset_output_oe;
  int err_total = 0;
  int n_tests = 0;

  always #12.5 aclk = ~aclk;

  wwds_top #(.KICK_TIMEOUT_CYC(TO), .RESET_PERIOD_CYC(RS)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .kick_input(kick), .mode_select(mode_select), .watchdog_enable(watchdog_enable),
    .supply_low(supply_low), .fault_output_i(fault_pin), .fault_output_o(fault_output_o),
    .fault_output_oe(fault_output_oe), .reset_output_i(reset_pin), .reset_output_o(reset_output_o),
    .reset_output_oe(reset_output_oe), .irq(irq)
  );

  wwds_mcu i_mcu (.aclk(aclk), .run(run), .gap(gap), .kick(kick));

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic fail();
    err_total++;
    end_sim();
  endtask : fail

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    bit ta = 0;
    bit tw = 0;
    bit dn = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (!ta && awready === 1'b1) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (!tw && wready === 1'b1) begin
        tw = 1;
        wvalid <= 1'b0;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        dn = 1;
      end
      if (++n > 40) fail();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    bit dn = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        dn = 1;
      end
      if (++n > 40) fail();
    end
  endtask : rd

  task automatic wait_oe(input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > lim) fail();
    end while (fault_output_oe !== v);
  endtask : wait_oe

  task automatic hi_cnt(input int len, output int n);
    n = 0;
    repeat (len) begin
      @(posedge aclk);
      if (fault_output_oe !== 1'b0) n++;
    end
  endtask : hi_cnt

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int n;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(OFS_TIMEOUT, d, r);
    `CHK(d, TO)
    rd(OFS_RESET, d, r);
    `CHK(d, RS)
    rd(OFS_INT_MASK, d, r);
    `CHK(d, 32'h0000_0000)
    rd(8'h14, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0000_0000})
    wr(8'h14, 32'h0000_0001, r);
    `CHK(r, RESP_SLVERR)
    wr(OFS_INT_MASK, 32'h0000_0007, r);
    rd(OFS_INT_MASK, d, r);
    `CHK(d, 32'h0000_0007)
    // window mode, shortest good spacing and a long one of 250 cycles
    gap <= 16'h0011;
    run <= 1'b1;
    watchdog_enable <= 1'b1;
    hi_cnt(600, n);
    `CHK(n, 0)
    gap <= 16'h00fa;
    hi_cnt(1000, n);
    `CHK(n, 0)
    rd(OFS_STATUS, d, r);
    `CHK(d[ST_WINDOW], 1'b1)
    // one cycle inside the closed window
    gap <= 16'h0010;
    wait_oe(1'b1, 600, n);
    run <= 1'b0;
    n = 0;
    while (fault_output_oe === 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    `CHK(n, 20)
    wait_oe(1'b1, 300, n);
    `CHK(n >= 250 && n <= 262, 1'b1)
    watchdog_enable <= 1'b0;
    rd(OFS_INT_STAT, d, r);
    `CHK(d, 32'h0000_0003)
    `CHK(irq, 1'b1)
    repeat (40) @(posedge aclk);
    wr(OFS_INT_STAT, 32'h0000_0007, r);
    rd(OFS_INT_STAT, d, r);
    `CHK(d, 32'h0000_0000)
    `CHK(irq, 1'b0)
    // mode moves only while disabled
    mode_select <= 1'b1;
    repeat (4) @(posedge aclk);
    watchdog_enable <= 1'b1;
    gap <= 16'h0008;
    run <= 1'b1;
    hi_cnt(800, n);
    `CHK(n, 0)
    run <= 1'b0;
    wait_oe(1'b1, 300, n);
    `CHK(n >= 240 && n <= 262, 1'b1)
    rd(OFS_INT_STAT, d, r);
    `CHK(d[INT_TIMEOUT], 1'b1)
    watchdog_enable <= 1'b0;
    repeat (40) @(posedge aclk);
    hi_cnt(700, n);
    `CHK(n, 0)
    supply_low <= 1'b1;
    wait_oe(1'b1, 8, n);
    `CHK(reset_output_oe, 1'b0)
    rd(OFS_INT_STAT, d, r);
    `CHK(d[INT_SUPPLY], 1'b1)
    `CHK({fault_output_o, reset_output_o}, 2'b00)
    rd(OFS_STATUS, d, r);
    `CHK({d[ST_RESET_PIN], d[ST_FAULT_PIN], d[ST_SUPPLY]}, 3'b101)
    supply_low <= 1'b0;
    wait_oe(1'b0, 40, n);
    `CHK(n >= 20, 1'b1)
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
